// ==== logic/sysopt_params.svh ====
// Constants for the system options and periodic wakeup block
//
// Overview of operation
// - Options-two bit 7 picks watchdog clock: 0 internal 1 kHz, 1 bus clock.
// - Only the first write to the watchdog clock select after reset takes effect.
// - Options-two bit 1 moves two-wire pins: 0 port A 2/3, 1 port B 6/7.
// - Options-two bit 0 set routes comparator output to timer capture channel 0.
// - Upper four bits of part id high are reserved; writes ignored, read zero.
// - Fixed 12-bit part id: bits 11:8 in high reg 3:0, 7:0 in low reg.
// - Wakeup register bit 7 is a read-only flag set on each timer timeout.
// - Writing one to wakeup bit 6 clears the flag; bit 6 always reads zero.
// - Wakeup bit 5 picks timer clock: 0 internal 1 kHz, 1 external clock.
// - Wakeup bit 4 enables flag interrupt requests; when clear, a timeout still requests via status bit 0 if mask bit 0 is set.
// - Wakeup bits 2:0 pick the period; code zero stops the timer.
// - Internal source codes 1..7 give 8,32,64,128,256,512,1024 ms on 1 ms ticks.
// - External source codes 1..7 give 256 up to 32768 external clock periods.
// - First timeout after setup may be up to one 1 kHz period short.
// - Watchdog period comes from clock select plus long timeout select together.
`ifndef SYSOPT_PARAMS_SVH
`define SYSOPT_PARAMS_SVH
`define ADDR_OPTIONS_TWO 4'h0
`define ADDR_PART_ID_HIGH 4'h4
`define ADDR_PART_ID_LOW 4'h8
`define ADDR_WAKEUP 4'hc
`define ADDR_IRQ_STATUS 4'h1
`define ADDR_IRQ_MASK 4'h2
`define BIT_WDOG_CLK 7
`define BIT_PIN_SEL 1
`define BIT_CMP_CAP 0
`define BIT_WK_FLAG 7
`define BIT_WK_CLEAR 6
`define BIT_WK_CLKSEL 5
`define BIT_WK_IE 4
`define OPTIONS_TWO_RESET 8'h00
`define WAKEUP_RESET 8'h00
`define OPTIONS_TWO_WMASK 8'h83
`define WAKEUP_WMASK 8'h37
`define PERIOD_OFF 3'h0
`define TICK_TIME_NS 1000000
`define CLOCK_PERIOD_NS 20
`define TICK_CYCLES (`TICK_TIME_NS / `CLOCK_PERIOD_NS)
`endif

// ==== logic/sysopt_pkg.sv ====
// Types for the system options and periodic wakeup block
package sysopt_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] addr_t;
	typedef logic [2:0] period_t;
endpackage

// ==== logic/system_options_and_periodic_wakeup.sv ====
// System options, part id and periodic wakeup timer register block
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "sysopt_params.svh"
module system_options_and_periodic_wakeup #(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	// Arbitrary neutral value, not a real part code
	parameter logic [11:0] PART_NUMBER = 12'h5a3
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// Register port
	input wire sysopt_pkg::addr_t i_addr,
	input wire sysopt_pkg::byte_t i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output sysopt_pkg::byte_t o_rdata,
	// Clocks and long timeout select from outside
	input wire logic i_ext_clock,
	input wire logic i_watchdog_long_timeout_select,
	// Watchdog configuration
	output logic o_watchdog_clock_select,
	output logic o_watchdog_long_timeout,
	// Pin routing
	output logic o_two_wire_on_port_b,
	output logic o_two_wire_on_port_a,
	output logic o_comparator_to_capture_enable,
	// Wakeup
	output logic o_wakeup_timeout_pulse,
	output logic o_irq
);
	import sysopt_pkg::*;

	byte_t opt_ff, nxt_opt;
	logic wlock_ff, nxt_wlock;
	byte_t wk_ff, nxt_wk;
	logic flag_ff, nxt_flag;
	logic [1:0] ist_ff, nxt_ist;
	logic [1:0] imask_ff, nxt_imask;
	byte_t rdata_ff, nxt_rdata;
	logic [17:0] tick_cnt_ff, nxt_tick_cnt;
	logic [15:0] per_cnt_ff, nxt_per_cnt;
	logic [1:0] ext_sync_ff;
	logic ext_prev_ff;
	logic pulse_ff, nxt_pulse;
	logic irq_ff, nxt_irq;
	logic [3:0] outs_ff, nxt_outs;
	// Port A select kept in its own flop so the output needs no inverter
	logic porta_ff, nxt_porta;
	logic [15:0] limit;
	logic advance;
	logic timeout;
	logic wr_opt, wr_wk;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			ext_sync_ff <= 2'h0;
			ext_prev_ff <= 1'b0;
		end else begin
			ext_sync_ff <= {ext_sync_ff[0], i_ext_clock};
			ext_prev_ff <= ext_sync_ff[1];
		end
	end

	assign wr_opt = i_write && (i_addr == `ADDR_OPTIONS_TWO);
	assign wr_wk = i_write && (i_addr == `ADDR_WAKEUP);

	// Period end count in units of the selected clock
	always_comb begin
		limit = 16'h0000;
		if (wk_ff[`BIT_WK_CLKSEL]) begin
			unique case (wk_ff[2:0])
				3'h1: limit = 16'h0100;
				3'h2: limit = 16'h0400;
				3'h3: limit = 16'h0800;
				3'h4: limit = 16'h1000;
				3'h5: limit = 16'h2000;
				3'h6: limit = 16'h4000;
				3'h7: limit = 16'h8000;
				default: limit = 16'h0000;
			endcase
		end else begin
			unique case (wk_ff[2:0])
				3'h1: limit = 16'h0008;
				3'h2: limit = 16'h0020;
				3'h3: limit = 16'h0040;
				3'h4: limit = 16'h0080;
				3'h5: limit = 16'h0100;
				3'h6: limit = 16'h0200;
				3'h7: limit = 16'h0400;
				default: limit = 16'h0000;
			endcase
		end
	end

	// Tick prescaler free runs, so the first period may be short by one tick
	always_comb begin
		nxt_tick_cnt = tick_cnt_ff + 18'h00001;
		if (tick_cnt_ff == 18'(TICK_CYCLES - 1)) begin
			nxt_tick_cnt = 18'h00000;
		end
		if (wk_ff[`BIT_WK_CLKSEL]) begin
			advance = ext_sync_ff[1] && !ext_prev_ff;
		end else begin
			advance = (tick_cnt_ff == 18'(TICK_CYCLES - 1));
		end
		timeout = 1'b0;
		nxt_per_cnt = per_cnt_ff;
		if (wk_ff[2:0] == `PERIOD_OFF) begin
			nxt_per_cnt = 16'h0000;
		end else if (wr_wk) begin
			nxt_per_cnt = 16'h0000;
		end else if (advance) begin
			if (per_cnt_ff >= limit - 16'h0001) begin
				nxt_per_cnt = 16'h0000;
				timeout = 1'b1;
			end else begin
				nxt_per_cnt = per_cnt_ff + 16'h0001;
			end
		end
		nxt_pulse = timeout;
	end

	// Register writes, flags and interrupt
	always_comb begin
		nxt_opt = opt_ff;
		nxt_wlock = wlock_ff;
		nxt_wk = wk_ff;
		nxt_flag = flag_ff;
		nxt_ist = ist_ff;
		nxt_imask = imask_ff;
		if (wr_opt) begin
			nxt_opt = (opt_ff & ~`OPTIONS_TWO_WMASK) | (i_wdata & `OPTIONS_TWO_WMASK);
			if (wlock_ff) begin
				nxt_opt[`BIT_WDOG_CLK] = opt_ff[`BIT_WDOG_CLK];
			end
			nxt_wlock = 1'b1;
		end
		if (wr_wk) begin
			nxt_wk = i_wdata & `WAKEUP_WMASK;
			if (i_wdata[`BIT_WK_CLEAR]) begin
				nxt_flag = 1'b0;
			end
		end
		if (i_write && (i_addr == `ADDR_IRQ_STATUS)) begin
			nxt_ist = ist_ff & ~i_wdata[1:0];
		end
		if (i_write && (i_addr == `ADDR_IRQ_MASK)) begin
			nxt_imask = i_wdata[1:0];
		end
		// Set beats clear in the same cycle
		if (timeout) begin
			nxt_flag = 1'b1;
			nxt_ist[0] = 1'b1;
		end
		if (wr_opt && wlock_ff && (i_wdata[`BIT_WDOG_CLK] != opt_ff[`BIT_WDOG_CLK])) begin
			nxt_ist[1] = 1'b1;
		end
		nxt_irq = (nxt_flag && nxt_wk[`BIT_WK_IE]) || |(nxt_ist & nxt_imask);
		nxt_outs = {nxt_opt[`BIT_WDOG_CLK], nxt_opt[`BIT_PIN_SEL], nxt_opt[`BIT_CMP_CAP],
			i_watchdog_long_timeout_select};
		nxt_porta = ~nxt_opt[`BIT_PIN_SEL];
	end

	// Read data, valid only the cycle after the strobe
	always_comb begin
		nxt_rdata = 8'h00;
		if (i_read) begin
			unique case (i_addr)
				`ADDR_OPTIONS_TWO: nxt_rdata = opt_ff & `OPTIONS_TWO_WMASK;
				`ADDR_PART_ID_HIGH: nxt_rdata = {4'h0, PART_NUMBER[11:8]};
				`ADDR_PART_ID_LOW: nxt_rdata = PART_NUMBER[7:0];
				`ADDR_WAKEUP: nxt_rdata = {flag_ff, 1'b0, wk_ff[5:0]};
				`ADDR_IRQ_STATUS: nxt_rdata = {6'h00, ist_ff};
				`ADDR_IRQ_MASK: nxt_rdata = {6'h00, imask_ff};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			opt_ff <= `OPTIONS_TWO_RESET;
			wlock_ff <= 1'b0;
			wk_ff <= `WAKEUP_RESET;
			flag_ff <= 1'b0;
			ist_ff <= 2'h0;
			imask_ff <= 2'h0;
			rdata_ff <= 8'h00;
			tick_cnt_ff <= 18'h00000;
			per_cnt_ff <= 16'h0000;
			pulse_ff <= 1'b0;
			irq_ff <= 1'b0;
			outs_ff <= 4'h0;
			porta_ff <= 1'b1;
		end else begin
			opt_ff <= nxt_opt;
			wlock_ff <= nxt_wlock;
			wk_ff <= nxt_wk;
			flag_ff <= nxt_flag;
			ist_ff <= nxt_ist;
			imask_ff <= nxt_imask;
			rdata_ff <= nxt_rdata;
			tick_cnt_ff <= nxt_tick_cnt;
			per_cnt_ff <= nxt_per_cnt;
			pulse_ff <= nxt_pulse;
			irq_ff <= nxt_irq;
			outs_ff <= nxt_outs;
			porta_ff <= nxt_porta;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_watchdog_clock_select = outs_ff[3];
	assign o_two_wire_on_port_b = outs_ff[2];
	assign o_two_wire_on_port_a = porta_ff;
	assign o_comparator_to_capture_enable = outs_ff[1];
	assign o_watchdog_long_timeout = outs_ff[0];
	assign o_wakeup_timeout_pulse = pulse_ff;
	assign o_irq = irq_ff;
endmodule

// ==== tb/sysopt_asserts.sv ====
// Property checker for the options and wakeup register block
`timescale 1ns/1ps
`include "sysopt_params.svh"
module sysopt_asserts #(
	parameter int TICK_CYCLES = 10,
	parameter logic [11:0] PART_NUMBER = 12'h000
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire sysopt_pkg::addr_t i_addr,
	input wire sysopt_pkg::byte_t i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	input wire sysopt_pkg::byte_t o_rdata,
	input wire logic o_watchdog_clock_select,
	input wire logic o_two_wire_on_port_b,
	input wire logic o_two_wire_on_port_a,
	input wire logic o_comparator_to_capture_enable,
	input wire logic o_wakeup_timeout_pulse
);
	import sysopt_pkg::*;
	logic seen_ff;
	logic nxt_seen;
	// Tracks the first options write, after which the clock select is frozen
	always_comb nxt_seen = seen_ff | (i_write && i_addr == `ADDR_OPTIONS_TWO);
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) seen_ff <= 1'b0;
		else seen_ff <= nxt_seen;
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	sequence opt_wr;
		i_write && i_addr == `ADDR_OPTIONS_TWO;
	endsequence
	sequence rd_at(addr_t a);
		i_read && i_addr == a;
	endsequence
	AST_ID_LOW: assert property (rd_at(`ADDR_PART_ID_LOW) |=> o_rdata == PART_NUMBER[7:0])
		else $error("part id low wrong");
	AST_ID_HIGH: assert property (rd_at(`ADDR_PART_ID_HIGH) |=> o_rdata[3:0] == PART_NUMBER[11:8])
		else $error("part id high wrong");
	AST_WK_READ: assert property (rd_at(`ADDR_WAKEUP) |=> !o_rdata[`BIT_WK_CLEAR])
		else $error("flag clear bit reads one");
	AST_FIRST: assert property (!seen_ff ##0 opt_wr |=> o_watchdog_clock_select == $past(i_wdata[7]))
		else $error("first clock select write lost");
	AST_LOCK: assert property (seen_ff ##0 opt_wr |=> $stable(o_watchdog_clock_select))
		else $error("clock select changed after lock");
	AST_OPT: assert property (opt_wr |=> o_two_wire_on_port_b == $past(i_wdata[1])
		&& o_comparator_to_capture_enable == $past(i_wdata[0]))
		else $error("options bits not taken");
	AST_PINS: assert property (o_two_wire_on_port_a != o_two_wire_on_port_b)
		else $error("pin routing not exclusive");
	AST_PULSE: assert property (o_wakeup_timeout_pulse |=> !o_wakeup_timeout_pulse)
		else $error("timeout pulse too long");
	AST_OFF: assert property (i_write && i_addr == `ADDR_WAKEUP && i_wdata[2:0] == `PERIOD_OFF
		|=> ##1 !o_wakeup_timeout_pulse[*6])
		else $error("timeout with period off");
endmodule
bind system_options_and_periodic_wakeup sysopt_asserts #(.TICK_CYCLES(TICK_CYCLES),
	.PART_NUMBER(PART_NUMBER)) chk (.*);

// ==== tb/tb_system_options_and_periodic_wakeup.sv ====
// Testbench for the options and wakeup register block
`timescale 1ns/1ps
`include "sysopt_params.svh"
module tb_system_options_and_periodic_wakeup;
	import sysopt_pkg::*;
	localparam int TK = 10;
	// Arbitrary part number
	localparam logic [11:0] PN = 12'h3c6;
	logic i_clock = 0, i_nrst = 0, i_write = 0, i_read = 0, i_ext_clock = 0;
	logic i_watchdog_long_timeout_select = 0, rd_q = 0;
	addr_t i_addr = '0;
	byte_t i_wdata = '0, o_rdata;
	logic o_watchdog_clock_select, o_watchdog_long_timeout, o_two_wire_on_port_b;
	logic o_two_wire_on_port_a, o_comparator_to_capture_enable, o_wakeup_timeout_pulse, o_irq;
	int mismatches = 0, num_checks = 0, n = 0, ec = 0;
	byte_t expq[$];
	logic [15:0] lfsr = 16'h5076;
	always #10 i_clock = ~i_clock;
	system_options_and_periodic_wakeup #(.TICK_CYCLES(TK), .PART_NUMBER(PN)) dut (.*);
	// Free running external clock, six bus cycles a period
	always @(posedge i_clock) begin
		ec <= (ec == 2) ? 0 : ec + 1;
		if (ec == 2) i_ext_clock <= ~i_ext_clock;
	end
	function automatic logic [15:0] lfsr_next(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic cmp(byte_t got, byte_t exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	always @(posedge i_clock) begin
		if (rd_q) cmp(o_rdata, expq.pop_front());
		rd_q <= i_read;
	end
	task automatic wr(addr_t a, byte_t d);
		i_addr <= a;
		i_wdata <= d;
		i_write <= 1'b1;
		@(posedge i_clock);
		i_write <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic rd(addr_t a, byte_t e);
		i_addr <= a;
		i_read <= 1'b1;
		expq.push_back(e);
		@(posedge i_clock);
		i_read <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic wait_pulse(input int lim, output int k);
		k = 0;
		do begin
			@(negedge i_clock);
			k++;
		end while (o_wakeup_timeout_pulse !== 1'b1 && k < lim);
		@(posedge i_clock);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200us;
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge i_clock);
		i_nrst <= 1'b1;
		@(posedge i_clock);
		rd(`ADDR_WAKEUP, `WAKEUP_RESET);
		rd(`ADDR_PART_ID_HIGH, {4'h0, PN[11:8]});
		wr(`ADDR_PART_ID_LOW, 8'hff);
		rd(`ADDR_PART_ID_LOW, PN[7:0]);
		rd(4'h7, 8'h00);
		wr(`ADDR_OPTIONS_TWO, 8'hff);
		rd(`ADDR_OPTIONS_TWO, 8'h83);
		cmp({o_two_wire_on_port_b, o_two_wire_on_port_a, o_comparator_to_capture_enable}, 8'h5);
		repeat (3) begin
			lfsr = lfsr_next(lfsr);
			i_watchdog_long_timeout_select <= lfsr[8];
			wr(`ADDR_OPTIONS_TWO, lfsr[7:0]);
			rd(`ADDR_OPTIONS_TWO, {6'h20, lfsr[1:0]});
			cmp(8'(o_watchdog_long_timeout), 8'(lfsr[8]));
		end
		// Locked write with the clock select cleared must be refused and flagged
		wr(`ADDR_OPTIONS_TWO, 8'h00);
		rd(`ADDR_OPTIONS_TWO, 8'h80);
		wr(`ADDR_WAKEUP, 8'h11);
		wait_pulse(200, n);
		cmp(8'(n >= 7 * TK - 2 && n <= 8 * TK + 2), 8'h01);
		cmp(8'(o_irq), 8'h01);
		wait_pulse(200, n);
		cmp(8'(n), 8'(8 * TK));
		rd(`ADDR_WAKEUP, 8'h91);
		wr(`ADDR_WAKEUP, 8'h41);
		rd(`ADDR_WAKEUP, 8'h01);
		wait_pulse(200, n);
		cmp(8'(o_irq), 8'h00);
		wr(`ADDR_WAKEUP, 8'h00);
		wait_pulse(200, n);
		cmp(8'(n), 8'd200);
		wr(`ADDR_WAKEUP, 8'h21);
		wait_pulse(2000, n);
		cmp(8'(n >= 256 * 6 - 8 && n <= 256 * 6 + 12), 8'h01);
		wr(`ADDR_WAKEUP, 8'h00);
		wr(`ADDR_IRQ_MASK, 8'h02);
		cmp(8'(o_irq), 8'h01);
		rd(`ADDR_IRQ_STATUS, 8'h03);
		wr(`ADDR_IRQ_STATUS, 8'h02);
		cmp(8'(o_irq), 8'h00);
		report_and_stop();
	end
endmodule
